// ===== core/rstat_pkg.sv
package rstat_pkg;
    // ---------------------------------------------
    // register offsets (byte address of low byte)
    // ---------------------------------------------
    localparam logic [6:0] RSTAT_OFF_CAPTURE = 7'h66;
    localparam logic [6:0] RSTAT_OFF_AVG_INFO = 7'h68;
    localparam logic [6:0] RSTAT_OFF_REC_COUNT = 7'h6A;
    localparam logic [6:0] RSTAT_OFF_X_BIN = 7'h6C;
    localparam logic [6:0] RSTAT_OFF_Y_BIN = 7'h6E;
    localparam logic [6:0] RSTAT_OFF_Z_BIN = 7'h70;
    localparam logic [6:0] RSTAT_OFF_SELECT = 7'h72;
    localparam logic [6:0] RSTAT_OFF_X_RESULT = 7'h74;
    localparam logic [6:0] RSTAT_OFF_Y_RESULT = 7'h76;
    // ---------------------------------------------
    // field layout and reset values
    // ---------------------------------------------
    localparam int RSTAT_RATE_LSB = 14;
    localparam int RSTAT_WIN_LSB = 12;
    localparam int RSTAT_AVG_W = 8;
    localparam int RSTAT_AVGSET_W = 4;
    localparam int RSTAT_COUNT_W = 4;
    localparam logic [3:0] RSTAT_COUNT_MAX = 4'h9;
    localparam int RSTAT_BIN_W = 12;
    localparam int RSTAT_SEL_W = 3;
    localparam logic [15:0] RSTAT_RESET_VAL = 16'h0000;
    localparam int RSTAT_FRAME_BITS = 16;

    typedef enum logic [2:0] {
        RSTAT_MEAN = 3'h0,
        RSTAT_STDDEV = 3'h1,
        RSTAT_PEAK = 3'h2,
        RSTAT_PEAK_PEAK = 3'h3,
        RSTAT_CREST = 3'h4,
        RSTAT_KURTOSIS = 3'h5,
        RSTAT_SKEW = 3'h6
    } rstat_metric_type;

    // capture settings from the spectral engine
    typedef struct packed {
        logic [1:0] sample_rate_option;
        logic [1:0] window;
        logic [7:0] fft_averages;
        logic [3:0] averaging_count_setting;
        logic spectrum_mode_valid;
    } rstat_capture_type;

    // per-axis statistic values, one per metric
    typedef struct packed {
        logic [6:0][15:0] x_val;
        logic [6:0][15:0] y_val;
    } rstat_stats_type;
endpackage

// ===== core/rstat_regs.sv
`timescale 1ns/10ps
module rstat_regs #(
    parameter int DATA_W = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // serial port (frame select active low)
    input wire logic sel_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    output logic miso_o,
    // engine side
    input wire rstat_pkg::rstat_capture_type capture_i,
    input wire logic [3:0] record_count_i,
    input wire logic [11:0] x_bin_i,
    input wire logic [11:0] y_bin_i,
    input wire logic [11:0] z_bin_i,
    input wire rstat_pkg::rstat_stats_type stats_i,
    output logic [2:0] metric_o
);
    import rstat_pkg::*;

    // ---------------------------------------------
    // serial frame capture
    // ---------------------------------------------
    // sclk sampled as data; mode 3: shift on rising, drive on falling
    logic sclk_d_reg, sclk_d_next;
    logic [4:0] bit_cnt_reg, bit_cnt_next;
    logic [15:0] shift_reg, shift_next;
    logic [15:0] tx_reg, tx_next;
    logic [6:0] rd_addr_reg, rd_addr_next;
    logic [2:0] sel_reg, sel_next;
    logic miso_reg, miso_next;
    logic [15:0] word;
    logic rise, fall;
    logic frame_end;
    // register views as the host reads them
    logic [15:0] capture_view, avg_view, count_view;
    logic [15:0] x_bin_view, y_bin_view, z_bin_view;
    logic [15:0] sel_view, x_result, y_result;
    logic [15:0] rd_word;

    // code 7 is unassigned; reads zero instead of an out-of-range slot
    function automatic logic [15:0] pick_result(
        input logic [6:0][15:0] vals,
        input logic [2:0] code
    );
        logic [15:0] v;
        v = RSTAT_RESET_VAL;
        if (code != 3'h7) begin
            v = vals[code];
        end
        return v;
    endfunction

    // zero-extend an alarm bin into a register word
    function automatic logic [15:0] widen_bin(input logic [11:0] b);
        logic [15:0] v;
        v = RSTAT_RESET_VAL;
        v[RSTAT_BIN_W-1:0] = b;
        return v;
    endfunction

    // ---------------------------------------------
    // read views
    // ---------------------------------------------
    always_comb begin
        capture_view = RSTAT_RESET_VAL;
        avg_view = RSTAT_RESET_VAL;
        count_view = RSTAT_RESET_VAL;
        sel_view = RSTAT_RESET_VAL;
        // contents undefined outside spectrum modes; shown as zero
        if (capture_i.spectrum_mode_valid) begin
            capture_view[RSTAT_RATE_LSB +: 2] = capture_i.sample_rate_option;
            capture_view[RSTAT_WIN_LSB +: 2] = capture_i.window;
            capture_view[RSTAT_AVG_W-1:0] = capture_i.fft_averages;
            avg_view[RSTAT_AVGSET_W-1:0] = capture_i.averaging_count_setting;
        end
        // clamp so a faulty engine count can never show 10 to 15
        if (record_count_i > RSTAT_COUNT_MAX) begin
            count_view[RSTAT_COUNT_W-1:0] = RSTAT_COUNT_MAX;
        end else begin
            count_view[RSTAT_COUNT_W-1:0] = record_count_i;
        end
        x_bin_view = widen_bin(x_bin_i);
        y_bin_view = widen_bin(y_bin_i);
        z_bin_view = widen_bin(z_bin_i);
        sel_view[RSTAT_SEL_W-1:0] = sel_reg;
        // metric passed through unchanged; engine supplies 8.8 or accel format
        x_result = pick_result(stats_i.x_val, sel_reg);
        y_result = pick_result(stats_i.y_val, sel_reg);
    end

    // odd byte address reads the same register as the even one
    always_comb begin
        rd_word = RSTAT_RESET_VAL;
        unique case ({rd_addr_reg[6:1], 1'b0})
            RSTAT_OFF_CAPTURE: rd_word = capture_view;
            RSTAT_OFF_AVG_INFO: rd_word = avg_view;
            RSTAT_OFF_REC_COUNT: rd_word = count_view;
            RSTAT_OFF_X_BIN: rd_word = x_bin_view;
            RSTAT_OFF_Y_BIN: rd_word = y_bin_view;
            RSTAT_OFF_Z_BIN: rd_word = z_bin_view;
            RSTAT_OFF_SELECT: rd_word = sel_view;
            RSTAT_OFF_X_RESULT: rd_word = x_result;
            RSTAT_OFF_Y_RESULT: rd_word = y_result;
            default: rd_word = RSTAT_RESET_VAL;
        endcase
    end

    // ---------------------------------------------
    // serial shift logic
    // ---------------------------------------------
    assign rise = sclk_i & ~sclk_d_reg;
    assign fall = ~sclk_i & sclk_d_reg;
    assign word = {shift_reg[14:0], mosi_i};
    assign frame_end = !sel_n_i && rise && bit_cnt_reg == 5'(RSTAT_FRAME_BITS - 1);

    always_comb begin
        sclk_d_next = sclk_i;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        rd_addr_next = rd_addr_reg;
        sel_next = sel_reg;
        miso_next = miso_reg;
        if (sel_n_i) begin
            bit_cnt_next = 5'h00;
            tx_next = rd_word;
            miso_next = 1'b0;
        end else begin
            if (rise) begin
                shift_next = word;
                bit_cnt_next = bit_cnt_reg + 5'h01;
                if (bit_cnt_reg == 5'(RSTAT_FRAME_BITS - 1)) begin
                    bit_cnt_next = 5'h00;
                    if (word[15]) begin
                        // only the selector low byte is writable
                        if (word[14:8] == RSTAT_OFF_SELECT) begin
                            sel_next = word[RSTAT_SEL_W-1:0];
                        end
                    end else begin
                        // read answer comes in the next frame
                        rd_addr_next = word[14:8];
                    end
                end
            end
            if (fall || (bit_cnt_reg == 5'h00 && !rise && sclk_i)) begin
                miso_next = tx_reg[15];
            end
            if (fall) begin
                tx_next = {tx_reg[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_d_reg <= 1'b1;
            bit_cnt_reg <= 5'h00;
            shift_reg <= 16'h0000;
            tx_reg <= 16'h0000;
            rd_addr_reg <= 7'h00;
            sel_reg <= 3'h0;
            miso_reg <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_d_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            rd_addr_reg <= rd_addr_next;
            sel_reg <= sel_next;
            miso_reg <= miso_next;
        end
    end

    assign miso_o = miso_reg;
    assign metric_o = sel_reg;

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    a_sel_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        frame_end && word[15] && word[14:8] == RSTAT_OFF_SELECT
        |=> sel_reg == $past(word[RSTAT_SEL_W-1:0]))
        else $error("selector not loaded by write frame");
    a_ro_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(frame_end && word[15] && word[14:8] == RSTAT_OFF_SELECT) |=> $stable(sel_reg))
        else $error("selector changed without a write to it");
    a_spare_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sel_reg == 3'h7 |-> x_result == RSTAT_RESET_VAL && y_result == RSTAT_RESET_VAL)
        else $error("unassigned selector code shows a value");
    a_frame_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sel_n_i |=> tx_reg == $past(rd_word))
        else $error("read word not loaded before frame");
    a_idle_miso: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sel_n_i |=> !miso_o && bit_cnt_reg == 5'h00)
        else $error("port not idle outside frame");
    a_count_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        count_view <= 16'(RSTAT_COUNT_MAX))
        else $error("record count out of range");
    a_bin_upper: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        x_bin_view[15:12] == 4'h0 && y_bin_view[15:12] == 4'h0
        && z_bin_view[15:12] == 4'h0)
        else $error("alarm bin upper bits set");
    a_x_result: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sel_reg != 3'h7 |-> x_result == stats_i.x_val[sel_reg]
        && y_result == stats_i.y_val[sel_reg])
        else $error("axis result not the selected metric");
    a_info_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !capture_i.spectrum_mode_valid |-> capture_view == RSTAT_RESET_VAL
        && avg_view == RSTAT_RESET_VAL)
        else $error("capture info shown outside spectrum mode");
    c_sel_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        $changed(sel_reg));
    c_skew: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        sel_reg == RSTAT_SKEW);
    c_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        $changed(rd_addr_reg));
    c_spare_code: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        sel_reg == 3'h7);
endmodule

// ===== test/rstat_host.sv
`timescale 1ns/10ps
module rstat_host (
    // clock
    input wire logic clk_i,
    // serial port
    output logic sel_n_o,
    output logic sclk_o,
    output logic mosi_o,
    input wire logic miso_i
);
    initial begin
        sel_n_o = 1'b1;
        sclk_o = 1'b1;
        mosi_o = 1'b0;
    end
    // each sclk phase lasts 3 clk, above the 2 clk floor
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge clk_i) sel_n_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        for (int i = 15; i >= 0; i--) begin
            sclk_o <= 1'b0;
            mosi_o <= tx[i];
            repeat (3) @(posedge clk_i);
            sclk_o <= 1'b1;
            rx[i] = miso_i;
            repeat (3) @(posedge clk_i);
        end
        sel_n_o <= 1'b1;
        // released line must not keep the last bit
        mosi_o <= ~mosi_o;
        repeat (3) @(posedge clk_i);
    endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/10ps
module testbench;
    import rstat_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sel_n, sclk, mosi, miso;
    rstat_capture_type cap = '0;
    logic [3:0] cnt = 4'h0;
    logic [11:0] xb = 12'h000, yb = 12'h000, zb = 12'h000;
    rstat_stats_type st = '0;
    logic [2:0] metric;
    logic [15:0] r;
    int fails = 0;
    int cmp_count = 0;
    initial forever #10 clk_i = ~clk_i;
    rstat_regs u_rstat_regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .sel_n_i(sel_n),
        .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso), .capture_i(cap),
        .record_count_i(cnt), .x_bin_i(xb), .y_bin_i(yb), .z_bin_i(zb),
        .stats_i(st), .metric_o(metric));
    rstat_host u_rstat_host (.clk_i(clk_i), .sel_n_o(sel_n), .sclk_o(sclk),
        .mosi_o(mosi), .miso_i(miso));
    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // read answer arrives in the following frame
    task automatic rd(input logic [6:0] a, input logic [15:0] m, input logic [15:0] e);
        u_rstat_host.xfer({1'b0, a, 8'h00}, r);
        u_rstat_host.xfer(16'h0000, r);
        check(r & m, e);
    endtask
    task automatic wr_sel(input logic [7:0] d);
        int n;
        n = 0;
        u_rstat_host.xfer({1'b1, RSTAT_OFF_SELECT, d}, r);
        while (metric !== d[2:0] && n < 8) begin
            @(posedge clk_i);
            n++;
        end
        if (metric !== d[2:0]) begin
            fails++;
            $display("wrong value at %0t: selector write not taken", $time);
            complete_run();
        end
    endtask
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_info();
        @(posedge clk_i);
        cap <= '{2'h2, 2'h1, 8'hA5, 4'hC, 1'b1};
        rd(RSTAT_OFF_CAPTURE, 16'hF0FF, 16'h90A5);
        rd(RSTAT_OFF_AVG_INFO, 16'h000F, 16'h000C);
        @(posedge clk_i);
        cap <= '{2'h3, 2'h3, 8'hFF, 4'hF, 1'b0};
        rd(RSTAT_OFF_CAPTURE, 16'hFFFF, 16'h0000);
    endtask
    task automatic t_count_bins();
        @(posedge clk_i);
        cnt <= 4'h9;
        xb <= 12'h7FF;
        yb <= 12'h123;
        zb <= 12'h5A5;
        rd(RSTAT_OFF_REC_COUNT, 16'hFFFF, 16'h0009);
        rd(RSTAT_OFF_X_BIN, 16'hFFFF, 16'h07FF);
        rd(RSTAT_OFF_Y_BIN, 16'hFFFF, 16'h0123);
        rd(RSTAT_OFF_Z_BIN, 16'hFFFF, 16'h05A5);
        rd(RSTAT_OFF_X_BIN | 7'h01, 16'hFFFF, 16'h07FF);
        cnt <= 4'hC;
        rd(RSTAT_OFF_REC_COUNT, 16'hFFFF, 16'h0009);
    endtask
    task automatic t_select();
        wr_sel(8'h02);
        check({13'h0, metric}, 16'h0002);
        for (int k = 0; k < 7; k++) begin
            wr_sel({5'h1F, 3'(k)});
            rd(RSTAT_OFF_SELECT, 16'h0007, 16'(k));
            rd(RSTAT_OFF_X_RESULT, 16'hFFFF, st.x_val[k]);
            rd(RSTAT_OFF_Y_RESULT, 16'hFFFF, st.y_val[k]);
        end
        wr_sel(8'h07);
        rd(RSTAT_OFF_X_RESULT, 16'hFFFF, 16'h0000);
        rd(RSTAT_OFF_Y_RESULT, 16'hFFFF, 16'h0000);
        wr_sel(8'h06);
        @(posedge clk_i);
        st.x_val[6] <= 16'h1AF2;
        rd(RSTAT_OFF_X_RESULT, 16'hFFFF, 16'h1AF2);
    endtask
    task automatic t_readonly();
        u_rstat_host.xfer({1'b1, RSTAT_OFF_REC_COUNT, 8'h55}, r);
        u_rstat_host.xfer({1'b1, RSTAT_OFF_X_RESULT, 8'h77}, r);
        rd(RSTAT_OFF_REC_COUNT, 16'hFFFF, 16'h0009);
        check({13'h0, metric}, 16'h0006);
    endtask
    // reset in mid-run must return the selector to mean
    task automatic t_reset();
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check({13'h0, metric}, 16'h0000);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rd(RSTAT_OFF_SELECT, 16'hFFFF, 16'h0000);
    endtask
    initial begin
        for (int k = 0; k < 7; k++) begin
            st.x_val[k] = 16'h016A + 16'(k * 257);
            st.y_val[k] = 16'hFF00 - 16'(k * 3);
        end
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rd(RSTAT_OFF_SELECT, 16'hFFFF, 16'h0000);
        t_info();
        t_count_bins();
        t_select();
        t_readonly();
        t_reset();
        complete_run();
    end
endmodule
